// file: inc/cbdc_defines.svh
// Purpose: offsets, field positions, reset values and counts
// Assumes: byte-wide register port, byte addresses as offsets
// Notes: definitions only, included by bare name
`ifndef CBDC_DEFINES_SVH
`define CBDC_DEFINES_SVH

// register offsets
`define CBDC_CARD_CTRL_OFS 8'h90
`define CBDC_DEV_CTRL_OFS 8'h92
`define CBDC_IRQ_STS_OFS 8'h94
`define CBDC_IRQ_MSK_OFS 8'h95

// card control fields
`define CBDC_CC_SPK_BIT 1
`define CBDC_CC_FLAG_BIT 0

// device control fields
`define CBDC_DC_LOCK_BIT 7
`define CBDC_DC_3V_BIT 6
`define CBDC_DC_DIAG_BIT 5
`define CBDC_DC_RSVD_BIT 4
`define CBDC_DC_TEST_BIT 3
`define CBDC_DC_MODE_HI 2
`define CBDC_DC_MODE_LO 1
`define CBDC_DC_NAND_BIT 0

// reset values and write masks
`define CBDC_DC_RESET 8'h66
`define CBDC_DC_WMASK 8'hef

// interrupt status bit positions
`define CBDC_EV_FUNC 0
`define CBDC_EV_REFUSE 1
`define CBDC_EV_IQDONE 2

// interrogation counter lengths in clock cycles
`define CBDC_INTERROG_LONG 1000
`define CBDC_INTERROG_SHORT 4

`endif

// file: inc/cbdc_pkg.sv
// Purpose: shared types of the bridge control block
// Assumes: nothing beyond the defines header
// Notes: types only, constants live in the defines header
package cbdc_pkg;

  // interrupt signalling choices
  typedef enum logic [1:0] {
    CBDC_MODE_PAR_PCI = 2'h0,
    CBDC_MODE_PAR_IRQ_PCI = 2'h1,
    CBDC_MODE_SER_IRQ_PAR_PCI = 2'h2,
    CBDC_MODE_SER_ALL = 2'h3
  } cbdc_irq_mode_t;

  // one-hot states of the interrogation counter
  typedef enum logic [1:0] {
    CBDC_IQ_IDLE = 2'b01,
    CBDC_IQ_RUN = 2'b10
  } cbdc_iq_state_t;

  // whole state of the top block
  typedef struct packed {
    logic spk_en;
    logic func_flag;
    logic [7:0] dev;
    logic [2:0] sts;
    logic [2:0] msk;
    logic [7:0] rdata;
    logic spk_out;
    logic pwr_off;
    logic irq;
  } cbdc_top_st_t;

endpackage

// file: rtl/cbdc_interrog.sv
// Purpose: interrogation counter with a shortened test length
// Assumes: start is a one-cycle pulse, ignored while running
// Notes: done is a registered one-cycle pulse at the end
`timescale 1ns/10ps
`default_nettype none
`include "cbdc_defines.svh"
module cbdc_interrog #(
  parameter int CW = 16,
  parameter int LONG_CNT = `CBDC_INTERROG_LONG,
  parameter int SHORT_CNT = `CBDC_INTERROG_SHORT
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic short_i,
  output logic busy_o,
  output logic done_o
);
  import cbdc_pkg::*;

  // counter state
  typedef struct packed {
    cbdc_iq_state_t fsm;
    logic [CW-1:0] cnt;
    logic busy; // registered copy of the run state
    logic done;
  } cbdc_iq_st_t;

  localparam logic [CW-1:0] LONG_V = CW'(LONG_CNT);
  localparam logic [CW-1:0] SHORT_V = CW'(SHORT_CNT);
  localparam logic [CW-1:0] ONE_V = {{(CW-1){1'b0}}, 1'b1};

  cbdc_iq_st_t st_r; // registered state
  cbdc_iq_st_t st_nxt; // next state

  // count down from the chosen length
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    case (st_r.fsm)
      CBDC_IQ_IDLE: begin
        if (start_i) begin
          st_nxt.fsm = CBDC_IQ_RUN;
          st_nxt.busy = 1'b1;
          // test setting picks the short length
          st_nxt.cnt = short_i ? SHORT_V : LONG_V; // RL11
        end
      end
      CBDC_IQ_RUN: begin
        if (st_r.cnt == ONE_V) begin
          st_nxt.fsm = CBDC_IQ_IDLE;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
        end
        st_nxt.cnt = st_r.cnt - ONE_V;
      end
      default: begin
        st_nxt.fsm = CBDC_IQ_IDLE;
        st_nxt.busy = 1'b0;
      end
    endcase
  end

  // register with freeze on clock enable
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r <= '{fsm: CBDC_IQ_IDLE, cnt: '0, busy: 1'b0, done: 1'b0};
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = st_r.busy; // straight from a flip-flop
  assign done_o = st_r.done;

  // short start loads the short length
  iq_short_load_a: assert property ( // RL11
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && start_i && short_i && st_r.fsm == CBDC_IQ_IDLE
    |=> st_r.cnt == SHORT_V)
    else $error("short interrogation length not loaded");
endmodule // cbdc_interrog
`default_nettype wire

// file: rtl/cbdc_nand_tree.sv
// Purpose: nand chain over the sampled input and two-way pins
// Assumes: only input or two-way pin levels are fed in
// Notes: output is registered, low while the chain is disabled
`timescale 1ns/10ps
`default_nettype none
module cbdc_nand_tree #(
  parameter int N = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic [N-1:0] pins_i,
  output logic out_o
);
  import cbdc_pkg::*;

  // chain state
  typedef struct packed {
    logic out;
  } cbdc_nt_st_t;

  cbdc_nt_st_t st_r; // registered state
  cbdc_nt_st_t st_nxt; // next state

  // each stage nands its pin with the previous stage
  function automatic logic chain(input logic [N-1:0] p);
    logic s;
    s = 1'b1;
    for (int k = 0; k < N; k++) begin
      s = ~(p[k] & s);
    end
    return s;
  endfunction

  // evaluate chain only while enabled
  always_comb begin
    st_nxt = st_r;
    st_nxt.out = en_i ? chain(pins_i) : 1'b0; // RL13
  end

  // register with freeze on clock enable
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r <= '{out: 1'b0};
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign out_o = st_r.out;

  // disabled chain shows low
  nand_idle_a: assert property ( // RL13
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && !en_i |=> !out_o)
    else $error("nand chain output not low while disabled");
endmodule // cbdc_nand_tree
`default_nettype wire

// file: rtl/cbdc_top.sv
// Purpose: card bridge control registers, speaker route, irq flag
// Assumes: byte register port, synchronous inputs, one clock
// Notes: read data stand in the cycle after the read strobe
//
// Contract
// RL1: enabled route passes card speaker to host
// RL2: disabled route holds host speaker output low
// RL3: card functional interrupt sets the flag
// RL4: writing one clears flag, zero keeps
// RL5: flag reads zero after reset
// RL6: device control at 92h, resets 66h
// RL7: lock bit blocks socket power-down in D3
// RL8: low-voltage capable force bit, default one
// RL9: diagnostic bit five, read/write, default one
// RL10: bit four reads zero, writes ignored
// RL11: test bit shortens interrogation counter
// RL12: mode field selects interrupt signalling, default 11
// RL13: bit zero enables nand tree chain
`timescale 1ns/10ps
`default_nettype none
`include "cbdc_defines.svh"
module cbdc_top #(
  parameter int NAND_W = 8,
  parameter int IQ_CW = 16,
  parameter int IQ_LONG = `CBDC_INTERROG_LONG,
  parameter int IQ_SHORT = `CBDC_INTERROG_SHORT
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic CARD_SPEAKER_IN_I,
  output logic HOST_SPEAKER_OUT_O,
  input wire logic CARD_FUNC_IRQ_I,
  input wire logic D3_STATE_I,
  input wire logic SOCKET_PWR_DOWN_REQ_I,
  input wire logic SOCKET_PWR_UP_REQ_I,
  output logic SOCKET_PWR_OFF_O,
  output logic LOW_VOLT_CAPABLE_O,
  output logic DIAG_BIT_FIVE_O,
  output cbdc_pkg::cbdc_irq_mode_t IRQ_SIGNALLING_SELECT_O,
  input wire logic INTERROG_START_I,
  output logic INTERROG_BUSY_O,
  output logic INTERROG_DONE_O,
  output logic NAND_TREE_EN_O,
  input wire logic [NAND_W-1:0] NAND_PINS_I,
  output logic NAND_TREE_OUT_O,
  output logic IRQ_O
);
  import cbdc_pkg::*;

  // reset image of the whole state
  localparam cbdc_top_st_t TOP_RST = '{
    spk_en: 1'b0,
    func_flag: 1'b0,
    dev: `CBDC_DC_RESET,
    sts: 3'h0,
    msk: 3'h0,
    rdata: 8'h00,
    spk_out: 1'b0,
    pwr_off: 1'b0,
    irq: 1'b0
  };

  cbdc_top_st_t st_r; // registered state
  cbdc_top_st_t st_nxt; // next state

  logic wr_cc; // write to card control
  logic wr_dc; // write to device control
  logic wr_sts; // write to interrupt status
  logic wr_msk; // write to interrupt mask
  logic refused; // power-down request blocked
  logic iq_done; // interrogation finished pulse
  logic iq_busy; // interrogation running
  logic [2:0] ev; // events feeding the status bits

  // exact byte address match
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // write strobes per register
  assign wr_cc = WR_I && hit(ADDR_I, `CBDC_CARD_CTRL_OFS);
  assign wr_dc = WR_I && hit(ADDR_I, `CBDC_DEV_CTRL_OFS); // RL6
  assign wr_sts = WR_I && hit(ADDR_I, `CBDC_IRQ_STS_OFS);
  assign wr_msk = WR_I && hit(ADDR_I, `CBDC_IRQ_MSK_OFS);

  // power-down asked while locked in low power state
  assign refused = SOCKET_PWR_DOWN_REQ_I && D3_STATE_I &&
                   st_r.dev[`CBDC_DC_LOCK_BIT]; // RL7

  // events, one bit each
  always_comb begin
    ev = 3'h0;
    ev[`CBDC_EV_FUNC] = CARD_FUNC_IRQ_I;
    ev[`CBDC_EV_REFUSE] = refused;
    ev[`CBDC_EV_IQDONE] = iq_done;
  end

  // next-state logic of every field of st_r
  always_comb begin
    st_nxt = st_r;
    // speaker route, enable decides what the host sees
    if (st_r.spk_en) begin
      st_nxt.spk_out = CARD_SPEAKER_IN_I; // RL1
    end else begin
      st_nxt.spk_out = 1'b0; // RL2
    end
    // card control write, enable bit plain read/write
    if (wr_cc) begin
      st_nxt.spk_en = WDATA_I[`CBDC_CC_SPK_BIT];
    end
    // a written one clears the flag, zero leaves it
    if (wr_cc && WDATA_I[`CBDC_CC_FLAG_BIT]) begin
      st_nxt.func_flag = 1'b0; // RL4
    end
    // a new card interrupt wins over a clear
    if (CARD_FUNC_IRQ_I) begin
      st_nxt.func_flag = 1'b1; // RL3
    end
    // device control, reserved bit four masked out
    if (wr_dc) begin
      st_nxt.dev = WDATA_I & `CBDC_DC_WMASK; // RL10 RL8 RL9 RL12 RL13
    end
    // status clears by writing ones, set wins
    if (wr_sts) begin
      st_nxt.sts = (st_r.sts & ~WDATA_I[2:0]) | ev;
    end else begin
      st_nxt.sts = st_r.sts | ev;
    end
    // mask register
    if (wr_msk) begin
      st_nxt.msk = WDATA_I[2:0];
    end
    // interrupt line from unmasked status
    st_nxt.irq = |(st_r.sts & st_r.msk);
    // socket power control, blocked requests ignored
    if (SOCKET_PWR_DOWN_REQ_I && !refused) begin
      st_nxt.pwr_off = 1'b1; // RL7
    end else if (SOCKET_PWR_UP_REQ_I) begin
      st_nxt.pwr_off = 1'b0;
    end
    // read data for one cycle only
    st_nxt.rdata = 8'h00;
    if (RD_I) begin
      if (hit(ADDR_I, `CBDC_CARD_CTRL_OFS)) begin
        st_nxt.rdata[`CBDC_CC_SPK_BIT] = st_r.spk_en;
        st_nxt.rdata[`CBDC_CC_FLAG_BIT] = st_r.func_flag;
      end else if (hit(ADDR_I, `CBDC_DEV_CTRL_OFS)) begin
        st_nxt.rdata = st_r.dev & `CBDC_DC_WMASK; // RL10
      end else if (hit(ADDR_I, `CBDC_IRQ_STS_OFS)) begin
        st_nxt.rdata = {5'h00, st_r.sts};
      end else if (hit(ADDR_I, `CBDC_IRQ_MSK_OFS)) begin
        st_nxt.rdata = {5'h00, st_r.msk};
      end else begin
        // unmapped addresses read as zero
        st_nxt.rdata = 8'h00;
      end
    end
  end

  // state register, reset beats the clock enable
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      st_r <= TOP_RST; // RL5 RL6
    end else if (CE_I) begin
      st_r <= st_nxt;
    end
  end

  // interrogation counter, test bit shortens it
  cbdc_interrog #(
    .CW(IQ_CW),
    .LONG_CNT(IQ_LONG),
    .SHORT_CNT(IQ_SHORT)
  ) u_interrog (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .start_i(INTERROG_START_I),
    .short_i(st_r.dev[`CBDC_DC_TEST_BIT]), // RL11
    .busy_o(iq_busy),
    .done_o(iq_done)
  );

  // nand chain, enabled from bit zero
  cbdc_nand_tree #(
    .N(NAND_W)
  ) u_nand (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .en_i(st_r.dev[`CBDC_DC_NAND_BIT]), // RL13
    .pins_i(NAND_PINS_I),
    .out_o(NAND_TREE_OUT_O)
  );

  // outputs straight from registers
  assign RDATA_O = st_r.rdata;
  assign HOST_SPEAKER_OUT_O = st_r.spk_out;
  assign SOCKET_PWR_OFF_O = st_r.pwr_off;
  assign LOW_VOLT_CAPABLE_O = st_r.dev[`CBDC_DC_3V_BIT]; // RL8
  assign DIAG_BIT_FIVE_O = st_r.dev[`CBDC_DC_DIAG_BIT]; // RL9
  assign IRQ_SIGNALLING_SELECT_O = cbdc_irq_mode_t'(
    st_r.dev[`CBDC_DC_MODE_HI:`CBDC_DC_MODE_LO]); // RL12
  assign NAND_TREE_EN_O = st_r.dev[`CBDC_DC_NAND_BIT];
  assign INTERROG_BUSY_O = iq_busy;
  assign INTERROG_DONE_O = iq_done;
  assign IRQ_O = st_r.irq;

  // checks on the registered behaviour
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // clear write with no competing interrupt
  sequence cc_clear_s;
    CE_I && wr_cc && WDATA_I[`CBDC_CC_FLAG_BIT] && !CARD_FUNC_IRQ_I;
  endsequence

  // write of zero to a set flag
  sequence cc_keep_s;
    CE_I && wr_cc && !WDATA_I[`CBDC_CC_FLAG_BIT] && st_r.func_flag;
  endsequence

  // read of device control
  sequence dc_read_s;
    CE_I && RD_I && hit(ADDR_I, `CBDC_DEV_CTRL_OFS);
  endsequence

  spk_route_a: assert property ( // RL1
    CE_I && st_r.spk_en && CARD_SPEAKER_IN_I |=> HOST_SPEAKER_OUT_O)
    else $error("speaker not passed while route enabled");

  spk_mute_a: assert property ( // RL2
    CE_I && !st_r.spk_en |=> !HOST_SPEAKER_OUT_O)
    else $error("speaker output active while route disabled");

  flag_set_a: assert property ( // RL3
    CE_I && CARD_FUNC_IRQ_I |=> st_r.func_flag && st_r.sts[0])
    else $error("card interrupt did not set the flag");

  flag_clear_a: assert property ( // RL4
    cc_clear_s |=> !st_r.func_flag)
    else $error("flag not cleared by writing one");

  flag_keep_a: assert property ( // RL4
    cc_keep_s |=> st_r.func_flag)
    else $error("flag changed by writing zero");

  reset_image_a: assert property ( // RL5
    $rose(RSTN_I) |-> !st_r.func_flag && st_r.dev == `CBDC_DC_RESET)
    else $error("reset values wrong after release");

  pwr_lock_a: assert property ( // RL7
    CE_I && refused |=> !$rose(SOCKET_PWR_OFF_O))
    else $error("socket powered down while locked in D3");

  // a refused power-down is recorded in status
  refuse_sts_a: assert property ( // RL7
    CE_I && refused |=> st_r.sts[`CBDC_EV_REFUSE])
    else $error("refused power-down not recorded in status");

  rsvd_read_a: assert property ( // RL10
    dc_read_s |=> !RDATA_O[`CBDC_DC_RSVD_BIT])
    else $error("reserved device control bit read as one");

  mode_write_a: assert property ( // RL12
    CE_I && wr_dc |=> IRQ_SIGNALLING_SELECT_O ==
      $past(WDATA_I[`CBDC_DC_MODE_HI:`CBDC_DC_MODE_LO]))
    else $error("interrupt mode field not taken from write");

  // low-voltage force bit follows a write
  low_volt_a: assert property ( // RL8
    CE_I && wr_dc |=> LOW_VOLT_CAPABLE_O ==
      $past(WDATA_I[`CBDC_DC_3V_BIT]))
    else $error("low-voltage force bit not taken from write");

  // diagnostic bit five follows a write
  diag_bit_a: assert property ( // RL9
    CE_I && wr_dc |=> DIAG_BIT_FIVE_O ==
      $past(WDATA_I[`CBDC_DC_DIAG_BIT]))
    else $error("diagnostic bit not taken from write");

  // nand chain enable follows a write
  nand_en_a: assert property ( // RL13
    CE_I && wr_dc |=> NAND_TREE_EN_O ==
      $past(WDATA_I[`CBDC_DC_NAND_BIT]))
    else $error("nand chain enable not taken from write");

  // reserved bit never stored by a write
  rsvd_keep_a: assert property ( // RL10
    CE_I && wr_dc |=> !st_r.dev[`CBDC_DC_RSVD_BIT])
    else $error("reserved device control bit stored");

  // reset image seen on the device control outputs
  reset_outs_a: assert property ( // RL6
    $rose(RSTN_I) |-> LOW_VOLT_CAPABLE_O && DIAG_BIT_FIVE_O &&
      IRQ_SIGNALLING_SELECT_O == CBDC_MODE_SER_ALL && !NAND_TREE_EN_O)
    else $error("device control outputs wrong after reset");

  // unmasked status raises the line next cycle
  irq_set_a: assert property (
    CE_I && |(st_r.sts & st_r.msk) |=> IRQ_O)
    else $error("interrupt line low with unmasked status set");

  // no unmasked status drops the line next cycle
  irq_clr_a: assert property (
    CE_I && !(|(st_r.sts & st_r.msk)) |=> !IRQ_O)
    else $error("interrupt line high with no unmasked status");
endmodule // cbdc_top
`default_nettype wire

// file: dv/cbdc_card_model.sv
// Purpose: card side of the socket: speaker, interrupt, test pins
// Assumes: one clock, the bench asks for functional interrupts
// Notes: speaker and pins move every cycle, interrupt follows the request one cycle later
`timescale 1ns/10ps
`default_nettype none
module cbdc_card_model #(
  parameter int N = 8
) (
  input wire logic clk_i,
  input wire logic irq_req_i,
  output logic spk_o,
  output logic func_irq_o,
  output logic [N-1:0] pins_o
);
  // quiet levels before the first edge
  initial begin
    spk_o = 1'b0;
    func_irq_o = 1'b0;
    pins_o = '0;
  end

  // fresh random levels each cycle so a stale sample differs on many cycles
  always @(posedge clk_i) begin
    spk_o <= 1'($urandom);
    pins_o <= N'($urandom);
    func_irq_o <= irq_req_i; // one card interrupt per request
  end
endmodule // cbdc_card_model
`default_nettype wire

// file: dv/testbench.sv
// Purpose: self-checking bench of the bridge control registers
// Assumes: card model on the far side, fixed seed
// Notes: short interrogation lengths keep the run brief
`timescale 1ns/10ps
`default_nettype none
`include "cbdc_defines.svh"
module testbench;
  import cbdc_pkg::*;
  localparam int LONG = 20; // shortened long count
  localparam int SHORT = 4; // test-bit count
  logic clk, rstn, wr, rd, d3, dn, up, iq, irq_cmd;
  logic [7:0] addr, wdata, rdata, pins, pins_d, v, e;
  logic spk, spk_d, fi, hout, pwr, lv, dg, nen, nout, irq, busy, done;
  cbdc_irq_mode_t mode;
  int fail_count, checked, i, n;

  // device under test, clock enable held on
  cbdc_top #(.IQ_LONG(LONG), .IQ_SHORT(SHORT)) u_dut (
    .REF_CLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .CARD_SPEAKER_IN_I(spk), .HOST_SPEAKER_OUT_O(hout),
    .CARD_FUNC_IRQ_I(fi), .D3_STATE_I(d3), .SOCKET_PWR_DOWN_REQ_I(dn),
    .SOCKET_PWR_UP_REQ_I(up), .SOCKET_PWR_OFF_O(pwr),
    .LOW_VOLT_CAPABLE_O(lv), .DIAG_BIT_FIVE_O(dg),
    .IRQ_SIGNALLING_SELECT_O(mode), .INTERROG_START_I(iq),
    .INTERROG_BUSY_O(busy), .INTERROG_DONE_O(done),
    .NAND_TREE_EN_O(nen), .NAND_PINS_I(pins), .NAND_TREE_OUT_O(nout),
    .IRQ_O(irq));

  // far side of the socket
  cbdc_card_model #(.N(8)) u_card (.clk_i(clk), .irq_req_i(irq_cmd),
    .spk_o(spk), .func_irq_o(fi), .pins_o(pins));

  // clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // what the design sampled at the last edge
  always @(posedge clk) begin
    spk_d <= spk;
    pins_d <= pins;
  end

  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // wait k edges, then let their updates land
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // one-cycle register write
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // expected chain output for sampled pin levels
  function automatic logic nand_exp(input logic [7:0] p);
    logic t;
    t = 1'b1;
    for (int k = 0; k < 8; k++) t = ~(p[k] & t);
    return t;
  endfunction

  // one request pulse on a socket control line
  task automatic pulse_dn_up(input logic down);
    @(posedge clk);
    if (down) dn <= 1'b1;
    else up <= 1'b1;
    @(posedge clk);
    dn <= 1'b0;
    up <= 1'b0;
    tick(2);
  endtask

  // run the counter, count edges from start to done
  task automatic interrog(input logic [7:0] dc, input int len);
    wreg(`CBDC_DEV_CTRL_OFS, dc);
    @(posedge clk);
    iq <= 1'b1;
    @(posedge clk);
    iq <= 1'b0;
    n = 0;
    do begin
      tick(1);
      n++;
      if (n == 1) chk(8'(busy), 8'h01);
    end while (done !== 1'b1 && n < 200);
    chk(8'(n), 8'(len));
  endtask

  // end of run, single verdict
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    {rstn, wr, rd, d3, dn, up, iq, irq_cmd} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    fail_count = 0;
    checked = 0;
    void'($urandom(63739));
    for (i = 0; i < 2; i++) begin
      // reset, a second time in mid-run after dirtying state
      if (i == 1) wreg(`CBDC_DEV_CTRL_OFS, 8'h81);
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rreg(`CBDC_DEV_CTRL_OFS, v);
      chk(v, 8'h66);
      chk({3'h0, lv, dg, nen, mode}, 8'h1b);
      rreg(`CBDC_CARD_CTRL_OFS, v);
      chk(v, 8'h00);
    end
    rreg(8'h33, v);
    chk(v, 8'h00);
    // random writes, every mode, reserved bit set on half
    for (i = 0; i < 16; i++) begin
      v = 8'($urandom);
      v[2:1] = i[1:0];
      v[4] = ~i[2];
      v[3] = 1'b0;
      wreg(`CBDC_DEV_CTRL_OFS, v);
      rreg(`CBDC_DEV_CTRL_OFS, e);
      chk(e, v & 8'hef);
      chk({3'h0, lv, dg, nen, mode}, {3'h0, v[6:5], v[0], v[2:1]});
    end
    // test chain on, then off
    wreg(`CBDC_DEV_CTRL_OFS, 8'h67);
    repeat (8) begin
      tick(1);
      chk(8'(nout), 8'(nand_exp(pins_d)));
    end
    wreg(`CBDC_DEV_CTRL_OFS, 8'h66);
    tick(2);
    chk(8'(nout), 8'h00);
    // speaker route on, then off
    for (i = 0; i < 2; i++) begin
      wreg(`CBDC_CARD_CTRL_OFS, {6'h0, ~i[0], 1'b0});
      tick(1);
      repeat (12) begin
        tick(1);
        chk(8'(hout), 8'(spk_d & ~i[0]));
      end
    end
    // card interrupt: flag, mask, clear by one only
    wreg(`CBDC_IRQ_MSK_OFS, 8'h01);
    @(posedge clk);
    irq_cmd <= 1'b1;
    @(posedge clk);
    irq_cmd <= 1'b0;
    tick(4);
    chk(8'(irq), 8'h01);
    rreg(`CBDC_CARD_CTRL_OFS, v);
    chk(v, 8'h01);
    wreg(`CBDC_CARD_CTRL_OFS, 8'h00);
    rreg(`CBDC_CARD_CTRL_OFS, v);
    chk(v, 8'h01);
    wreg(`CBDC_CARD_CTRL_OFS, 8'h01);
    wreg(`CBDC_IRQ_STS_OFS, 8'h01);
    rreg(`CBDC_CARD_CTRL_OFS, v);
    chk(v, 8'h00);
    tick(1);
    chk(8'(irq), 8'h00);
    // socket power held while locked in D3
    d3 <= 1'b1;
    wreg(`CBDC_IRQ_MSK_OFS, 8'h00);
    wreg(`CBDC_DEV_CTRL_OFS, 8'he6);
    pulse_dn_up(1'b1);
    chk(8'(pwr), 8'h00);
    rreg(`CBDC_IRQ_STS_OFS, v);
    chk(v & 8'h02, 8'h02);
    chk(8'(irq), 8'h00);
    wreg(`CBDC_DEV_CTRL_OFS, 8'h66);
    pulse_dn_up(1'b1);
    chk(8'(pwr), 8'h01);
    pulse_dn_up(1'b0);
    chk(8'(pwr), 8'h00);
    d3 <= 1'b0;
    // interrogation counter, test bit set and clear
    interrog(8'h6e, SHORT);
    interrog(8'h66, LONG);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
